// ===== verilog/rsq_pkg.sv
package rsq_pkg;

  // Clock and timebase
  localparam int CLK_HZ       = 10_000_000;
  localparam int CYC_PER_MS   = CLK_HZ / 1000;
  localparam int TICK_PER_MS  = 16;
  localparam int TICK_FRAC    = 4;
  localparam int CYC_PER_TICK = CYC_PER_MS / TICK_PER_MS;
  localparam logic [9:0] TICK_LAST = 10'(CYC_PER_TICK - 1);

  // Widths
  localparam int CNT_W  = 24;
  localparam int MV_W   = 13;
  localparam int ACC_W  = 27;
  localparam int LIN_W  = 16;
  localparam int REG_N  = 11;
  localparam int CONV_N = 12;

  // Ramp limits
  localparam int RAMP_MIN_US     = 250;
  localparam int RAMP_MAX_MS     = 1300;
  localparam int MAX_SLOPE_MV_MS = 4000;
  localparam logic [CNT_W-1:0] RAMP_MIN_TICKS =
    CNT_W'(RAMP_MIN_US * TICK_PER_MS / 1000);
  localparam logic [CNT_W-1:0] RAMP_MAX_TICKS =
    CNT_W'(RAMP_MAX_MS * TICK_PER_MS);
  localparam logic [1:0] GAP_RELOAD =
    2'((CYC_PER_MS + MAX_SLOPE_MV_MS - 1) / MAX_SLOPE_MV_MS - 1);
  localparam logic [ACC_W-1:0] SLEW_THR =
    ACC_W'(TICK_PER_MS * CYC_PER_MS / 1000);

  // Command codes
  localparam logic [7:0] CMD_SLEW     = 8'h27;
  localparam logic [7:0] CMD_ON_DLY   = 8'h60;
  localparam logic [7:0] CMD_RISE     = 8'h61;
  localparam logic [7:0] CMD_ON_MAX   = 8'h62;
  localparam logic [7:0] CMD_OFF_DLY  = 8'h64;
  localparam logic [7:0] CMD_FALL     = 8'h65;
  localparam logic [7:0] CMD_OFF_WARN = 8'h66;
  localparam logic [7:0] CMD_RETRY    = 8'hDB;
  localparam logic [7:0] CMD_RESTART  = 8'hDC;
  localparam logic [7:0] CMD_OT_WARN  = 8'h51;
  localparam logic [7:0] CMD_UT_FAULT = 8'h53;

  // Register and converter indices
  localparam logic [3:0] IDX_SLEW     = 4'h0;
  localparam logic [3:0] IDX_ON_DLY   = 4'h1;
  localparam logic [3:0] IDX_RISE     = 4'h2;
  localparam logic [3:0] IDX_ON_MAX   = 4'h3;
  localparam logic [3:0] IDX_OFF_DLY  = 4'h4;
  localparam logic [3:0] IDX_FALL     = 4'h5;
  localparam logic [3:0] IDX_OFF_WARN = 4'h6;
  localparam logic [3:0] IDX_RETRY    = 4'h7;
  localparam logic [3:0] IDX_RESTART  = 4'h8;
  localparam logic [3:0] IDX_OT       = 4'h9;
  localparam logic [3:0] IDX_UT       = 4'hA;
  localparam logic [3:0] IDX_TEMP     = 4'hB;
  localparam logic [3:0] IDX_NONE     = 4'hF;

  // Reset values
  localparam logic [REG_N-1:0][LIN_W-1:0] REG_RST_ALL = {
    16'hE580, 16'hEAA8, 16'hFBE8, 16'hFABC, 16'hF258, 16'hD200,
    16'h8000, 16'hD280, 16'hD200, 16'h8000, 16'hAA00};

  // Status bit positions
  localparam int STB_TEMP     = 2;
  localparam int STT_OT_WARN  = 6;
  localparam int STT_UT_FAULT = 4;

  typedef enum logic [8:0] {
    ST_OFF        = 9'b0_0000_0001,
    ST_ON_DELAY   = 9'b0_0000_0010,
    ST_RISE       = 9'b0_0000_0100,
    ST_ON         = 9'b0_0000_1000,
    ST_OFF_DELAY  = 9'b0_0001_0000,
    ST_FALL       = 9'b0_0010_0000,
    ST_DECAY      = 9'b0_0100_0000,
    ST_RETRY_WAIT = 9'b0_1000_0000,
    ST_SPARE      = 9'b1_0000_0000
  } rsq_state_e;

  typedef struct packed {
    rsq_state_e                  st;
    logic [REG_N-1:0][LIN_W-1:0] regs;
    logic [LIN_W-1:0]            rd_data;
    logic                        ack;
    logic                        nak;
    logic [9:0]                  cyc;
    logic [CNT_W-1:0]            seq_cnt;
    logic [CNT_W-1:0]            retry_cnt;
    logic [CNT_W-1:0]            rst_cnt;
    logic [ACC_W-1:0]            acc;
    logic [MV_W-1:0]             dac;
    logic [MV_W-1:0]             ramp_mv;
    logic [1:0]                  gap;
    logic                        run_q;
    logic                        hold;
    logic                        retry_run;
    logic                        fault_seen;
    logic                        latched;
    logic                        uv_ok;
    logic                        drive;
    logic                        ot_warn;
    logic                        ut_fault;
    logic                        ton_fault;
    logic                        toff_warn;
    logic                        alert;
  } rsq_regs_s;

  localparam rsq_regs_s RSQ_RST = '{st: ST_OFF, regs: REG_RST_ALL,
                                    default: '0};

endpackage

// ===== verilog/rsq_lin11.sv
`timescale 1ns/1ns
module rsq_lin11 (
  // Linear 5s/11s word
  input  wire logic [rsq_pkg::LIN_W-1:0] lin_i,
  // Fixed point, four fraction bits
  output logic signed [31:0]             val_o
);
  import rsq_pkg::*;

  logic signed [5:0]  shift;
  logic signed [31:0] mant;

  always_comb
  begin
    shift = $signed({lin_i[15], lin_i[15:11]}) + 6'(TICK_FRAC);
    mant  = {{21{lin_i[10]}}, lin_i[10:0]};
    if (shift >= 0)
    begin
      val_o = mant <<< shift[4:0];
    end
    else
    begin
      val_o = mant >>> 6'(-shift);
    end
  end

endmodule

// ===== verilog/rsq_sequencer.sv
`timescale 1ns/1ns
module rsq_sequencer (
  // Clock and reset
  input  wire logic                        SYS_CLK_I,
  input  wire logic                        RST_I,
  // Command port
  input  wire logic                        CMD_WR_I,
  input  wire logic                        CMD_RD_I,
  input  wire logic [7:0]                  CMD_CODE_I,
  input  wire logic [rsq_pkg::LIN_W-1:0]   CMD_DATA_I,
  output logic      [rsq_pkg::LIN_W-1:0]   RD_DATA_O,
  output logic                             CMD_ACK_O,
  output logic                             CMD_NAK_O,
  // Run control
  input  wire logic                        RUN_I,
  output logic                             RUN_O,
  output logic                             RUN_OE_O,
  input  wire logic                        OP_ON_I,
  input  wire logic [rsq_pkg::MV_W-1:0]    SETPOINT_I,
  input  wire logic                        FAULT_I,
  input  wire logic                        FAULT_RETRY_I,
  input  wire logic                        DECAY_CHECK_EN_I,
  // Output sense
  input  wire logic                        VOUT_ABOVE_UV_I,
  input  wire logic                        VOUT_BELOW_DECAY_I,
  // Power stage
  output logic      [rsq_pkg::MV_W-1:0]    DAC_O,
  output logic                             DRIVE_EN_O,
  output logic                             DCM_O,
  // Temperature
  input  wire logic [rsq_pkg::LIN_W-1:0]   TEMP_I,
  input  wire logic                        TEMP_VALID_I,
  input  wire logic                        OT_WARN_MASK_I,
  input  wire logic                        UT_IGNORE_I,
  // Status
  input  wire logic                        STATUS_CLEAR_I,
  output logic      [7:0]                  STATUS_BYTE_O,
  output logic      [7:0]                  STATUS_TEMP_O,
  output logic                             TON_FAULT_O,
  output logic                             TOFF_WARN_O,
  output logic                             ALERT_O
);
  import rsq_pkg::*;

  rsq_regs_s r_ff;
  rsq_regs_s nxt_r;

  logic [CONV_N-1:0][LIN_W-1:0] lin_in;
  logic signed [31:0]           conv [CONV_N];
  logic [CNT_W-1:0]             t_on_dly;
  logic [CNT_W-1:0]             t_rise;
  logic [CNT_W-1:0]             t_on_max;
  logic [CNT_W-1:0]             t_off_dly;
  logic [CNT_W-1:0]             t_fall;
  logic [CNT_W-1:0]             t_off_warn;
  logic [CNT_W-1:0]             t_retry;
  logic [CNT_W-1:0]             t_restart;
  logic [CNT_W-1:0]             slew_ticks;
  logic [CNT_W-1:0]             t_rise_eff;
  logic [CNT_W-1:0]             t_fall_eff;
  logic [ACC_W-1:0]             rise_total;
  logic [ACC_W-1:0]             fall_total;
  logic [LIN_W-1:0]             slew_step;
  logic [3:0]                   wr_idx;
  logic                         tick;
  logic                         run_on;
  logic                         active;
  logic                         ton_expire;
  logic                         toff_hit;
  logic                         decay_done;
  logic                         rise_bypass;

  function automatic logic [3:0] reg_index(input logic [7:0] code);
    unique case (code)
      CMD_SLEW:     reg_index = IDX_SLEW;
      CMD_ON_DLY:   reg_index = IDX_ON_DLY;
      CMD_RISE:     reg_index = IDX_RISE;
      CMD_ON_MAX:   reg_index = IDX_ON_MAX;
      CMD_OFF_DLY:  reg_index = IDX_OFF_DLY;
      CMD_FALL:     reg_index = IDX_FALL;
      CMD_OFF_WARN: reg_index = IDX_OFF_WARN;
      CMD_RETRY:    reg_index = IDX_RETRY;
      CMD_RESTART:  reg_index = IDX_RESTART;
      CMD_OT_WARN:  reg_index = IDX_OT;
      CMD_UT_FAULT: reg_index = IDX_UT;
      default:      reg_index = IDX_NONE;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] to_ticks(input logic signed [31:0] v);
    if (v < 0)
    begin
      to_ticks = '0;
    end
    else if (v > 32'sh00FF_FFFF)
    begin
      to_ticks = '1;
    end
    else
    begin
      to_ticks = v[CNT_W-1:0];
    end
  endfunction

  function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] c);
    inc_sat = (c == '1) ? c : c + 24'h00_0001;
  endfunction

  assign lin_in = {TEMP_I, r_ff.regs};
  for (genvar g = 0; g < CONV_N; g++)
  begin : g_conv
    rsq_lin11 u_conv (
      .lin_i (lin_in[g]),
      .val_o (conv[g])
    );
  end

  assign t_on_dly   = to_ticks(conv[IDX_ON_DLY]);
  assign t_rise     = to_ticks(conv[IDX_RISE]);
  assign t_on_max   = to_ticks(conv[IDX_ON_MAX]);
  assign t_off_dly  = to_ticks(conv[IDX_OFF_DLY]);
  assign t_fall     = to_ticks(conv[IDX_FALL]);
  assign t_off_warn = to_ticks(conv[IDX_OFF_WARN]);
  assign t_retry    = to_ticks(conv[IDX_RETRY]);
  assign t_restart  = to_ticks(conv[IDX_RESTART]);
  assign slew_ticks = to_ticks(conv[IDX_SLEW]);
  assign slew_step  = (slew_ticks > 24'h00_FFFF) ?
                      16'hFFFF : slew_ticks[LIN_W-1:0];

  assign t_fall_eff = (t_fall < RAMP_MIN_TICKS) ? RAMP_MIN_TICKS :
                      (t_fall > RAMP_MAX_TICKS) ? RAMP_MAX_TICKS : t_fall;
  assign t_rise_eff = (t_rise > RAMP_MAX_TICKS) ? RAMP_MAX_TICKS : t_rise;
  assign rise_total = ACC_W'(t_rise_eff * CYC_PER_TICK);
  assign fall_total = ACC_W'(t_fall_eff * CYC_PER_TICK);
  assign rise_bypass = t_rise < RAMP_MIN_TICKS;

  assign tick    = r_ff.cyc == TICK_LAST;
  assign wr_idx  = reg_index(CMD_CODE_I);
  assign run_on  = RUN_I & OP_ON_I & ~r_ff.hold;
  assign active  = (r_ff.st == ST_ON_DELAY) | (r_ff.st == ST_RISE) |
                   (r_ff.st == ST_ON) | (r_ff.st == ST_OFF_DELAY);
  assign ton_expire = ((r_ff.st == ST_RISE) | (r_ff.st == ST_ON)) &
                      ~r_ff.uv_ok & ~VOUT_ABOVE_UV_I &
                      (t_on_max != '0) & (r_ff.seq_cnt >= t_on_max);
  assign toff_hit = (r_ff.st == ST_DECAY) & DECAY_CHECK_EN_I &
                    (t_off_warn != '0) & ~VOUT_BELOW_DECAY_I &
                    (r_ff.seq_cnt >= t_off_warn);
  assign decay_done = ~DECAY_CHECK_EN_I | VOUT_BELOW_DECAY_I;

  always_comb
  begin
    nxt_r     = r_ff;
    nxt_r.ack = 1'b0;
    nxt_r.nak = 1'b0;
    nxt_r.cyc = tick ? '0 : r_ff.cyc + 10'd1;
    nxt_r.run_q = RUN_I;
    if (tick)
    begin
      nxt_r.seq_cnt = inc_sat(r_ff.seq_cnt);
    end
    if (r_ff.gap != 2'd0)
    begin
      nxt_r.gap = r_ff.gap - 2'd1;
    end
    if (!run_on)
    begin
      nxt_r.latched = 1'b0;
    end

    // Command port
    if (CMD_WR_I)
    begin
      if (wr_idx != IDX_NONE)
      begin
        nxt_r.regs[wr_idx] = CMD_DATA_I;
        nxt_r.ack = 1'b1;
      end
      else
      begin
        nxt_r.nak = 1'b1;
      end
    end
    else if (CMD_RD_I)
    begin
      nxt_r.rd_data = '0;
      if (wr_idx != IDX_NONE)
      begin
        nxt_r.rd_data = r_ff.regs[wr_idx];
        nxt_r.ack = 1'b1;
      end
      else
      begin
        nxt_r.nak = 1'b1;
      end
    end

    // Restart hold on RUN falling edge
    if (r_ff.hold)
    begin
      if (tick)
      begin
        nxt_r.rst_cnt = inc_sat(r_ff.rst_cnt);
      end
      // Strict compare, never short by a partial tick
      if (r_ff.rst_cnt > t_restart)
      begin
        nxt_r.hold = 1'b0;
      end
    end
    else if (r_ff.run_q && !RUN_I)
    begin
      nxt_r.hold    = 1'b1;
      nxt_r.rst_cnt = '0;
    end

    if (r_ff.retry_run && tick)
    begin
      nxt_r.retry_cnt = inc_sat(r_ff.retry_cnt);
    end

    if ((FAULT_I || ton_expire) && active)
    begin
      nxt_r.st         = ST_FALL;
      nxt_r.acc        = '0;
      nxt_r.ramp_mv    = r_ff.dac;
      nxt_r.fault_seen = 1'b1;
      nxt_r.retry_run  = 1'b1;
      nxt_r.retry_cnt  = '0;
    end
    else
    begin
      unique case (r_ff.st)
        ST_OFF:
        begin
          if (run_on && !r_ff.latched && decay_done)
          begin
            nxt_r.st      = ST_ON_DELAY;
            nxt_r.seq_cnt = '0;
          end
        end
        ST_ON_DELAY:
        begin
          if (!run_on)
          begin
            nxt_r.st = ST_OFF;
          end
          else if (r_ff.seq_cnt > t_on_dly)
          begin
            nxt_r.st      = ST_RISE;
            nxt_r.seq_cnt = '0;
            nxt_r.acc     = '0;
            nxt_r.ramp_mv = SETPOINT_I;
            nxt_r.drive   = 1'b1;
            nxt_r.uv_ok   = 1'b0;
            if (rise_bypass)
            begin
              nxt_r.dac = SETPOINT_I;
            end
          end
        end
        ST_RISE:
        begin
          if (VOUT_ABOVE_UV_I)
          begin
            nxt_r.uv_ok = 1'b1;
          end
          if (!run_on)
          begin
            nxt_r.st      = ST_OFF_DELAY;
            nxt_r.seq_cnt = '0;
          end
          else if (r_ff.dac >= r_ff.ramp_mv)
          begin
            nxt_r.st  = ST_ON;
            nxt_r.acc = '0;
          end
          else if (r_ff.acc >= rise_total)
          begin
            if (r_ff.gap == 2'd0)
            begin
              nxt_r.acc = r_ff.acc - rise_total + ACC_W'(r_ff.ramp_mv);
              nxt_r.dac = r_ff.dac + 13'd1;
              nxt_r.gap = GAP_RELOAD;
            end
          end
          else
          begin
            nxt_r.acc = r_ff.acc + ACC_W'(r_ff.ramp_mv);
          end
        end
        ST_ON:
        begin
          if (VOUT_ABOVE_UV_I)
          begin
            nxt_r.uv_ok = 1'b1;
          end
          if (!run_on)
          begin
            nxt_r.st      = ST_OFF_DELAY;
            nxt_r.seq_cnt = '0;
          end
          else if (r_ff.dac == SETPOINT_I)
          begin
            nxt_r.acc = '0;
          end
          else if (r_ff.acc >= SLEW_THR)
          begin
            nxt_r.acc = r_ff.acc - SLEW_THR;
            nxt_r.dac = (r_ff.dac > SETPOINT_I) ? r_ff.dac - 13'd1 :
                                                  r_ff.dac + 13'd1;
          end
          else
          begin
            nxt_r.acc = r_ff.acc + ACC_W'(slew_step);
          end
        end
        ST_OFF_DELAY:
        begin
          if (r_ff.seq_cnt > t_off_dly)
          begin
            nxt_r.st      = ST_FALL;
            nxt_r.acc     = '0;
            nxt_r.ramp_mv = r_ff.dac;
          end
        end
        ST_FALL:
        begin
          if (r_ff.dac == '0)
          begin
            nxt_r.st      = ST_DECAY;
            nxt_r.drive   = 1'b0;
            nxt_r.seq_cnt = '0;
          end
          else if (r_ff.acc >= fall_total)
          begin
            if (r_ff.gap == 2'd0)
            begin
              nxt_r.acc = r_ff.acc - fall_total + ACC_W'(r_ff.ramp_mv);
              nxt_r.dac = r_ff.dac - 13'd1;
              nxt_r.gap = GAP_RELOAD;
            end
          end
          else
          begin
            nxt_r.acc = r_ff.acc + ACC_W'(r_ff.ramp_mv);
          end
        end
        ST_DECAY:
        begin
          if (decay_done)
          begin
            if (!r_ff.fault_seen)
            begin
              nxt_r.st = ST_OFF;
            end
            else if (FAULT_RETRY_I)
            begin
              nxt_r.st = ST_RETRY_WAIT;
            end
            else
            begin
              nxt_r.st         = ST_OFF;
              nxt_r.latched    = 1'b1;
              nxt_r.fault_seen = 1'b0;
              nxt_r.retry_run  = 1'b0;
            end
          end
        end
        ST_RETRY_WAIT:
        begin
          if (r_ff.retry_cnt >= t_retry)
          begin
            nxt_r.st         = ST_OFF;
            nxt_r.fault_seen = 1'b0;
            nxt_r.retry_run  = 1'b0;
          end
        end
        default:
        begin
          nxt_r.st = ST_OFF;
        end
      endcase
    end

    // Sticky flags, set wins over clear
    if (STATUS_CLEAR_I)
    begin
      nxt_r.ot_warn   = 1'b0;
      nxt_r.ut_fault  = 1'b0;
      nxt_r.ton_fault = 1'b0;
      nxt_r.toff_warn = 1'b0;
    end
    if (TEMP_VALID_I && (conv[IDX_TEMP] > conv[IDX_OT]))
    begin
      nxt_r.ot_warn = 1'b1;
    end
    if (TEMP_VALID_I && (conv[IDX_TEMP] < conv[IDX_UT]))
    begin
      nxt_r.ut_fault = 1'b1;
    end
    if (ton_expire)
    begin
      nxt_r.ton_fault = 1'b1;
    end
    if (toff_hit)
    begin
      nxt_r.toff_warn = 1'b1;
    end
    nxt_r.alert = (nxt_r.ot_warn & ~OT_WARN_MASK_I) |
                  (nxt_r.ut_fault & ~UT_IGNORE_I) |
                  nxt_r.ton_fault | nxt_r.toff_warn;
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      r_ff <= RSQ_RST;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // Outputs
  assign RD_DATA_O  = r_ff.rd_data;
  assign CMD_ACK_O  = r_ff.ack;
  assign CMD_NAK_O  = r_ff.nak;
  assign RUN_O      = 1'b0;
  assign RUN_OE_O   = r_ff.hold;
  assign DAC_O      = r_ff.dac;
  assign DRIVE_EN_O = r_ff.drive;
  assign DCM_O      = r_ff.st == ST_RISE;
  assign TON_FAULT_O = r_ff.ton_fault;
  assign TOFF_WARN_O = r_ff.toff_warn;
  assign ALERT_O     = r_ff.alert;

  always_comb
  begin
    STATUS_BYTE_O = 8'h00;
    STATUS_TEMP_O = 8'h00;
    STATUS_BYTE_O[STB_TEMP]     = r_ff.ot_warn | r_ff.ut_fault;
    STATUS_TEMP_O[STT_OT_WARN]  = r_ff.ot_warn;
    STATUS_TEMP_O[STT_UT_FAULT] = r_ff.ut_fault;
  end

endmodule

// ===== verif/rsq_sequencer_properties.sv
`timescale 1ns/1ns
module rsq_checker (
  // Clock and reset
  input  wire logic                     SYS_CLK_I,
  input  wire logic                     RST_I,
  // Command port
  input  wire logic                     CMD_WR_I,
  input  wire logic                     CMD_RD_I,
  input  wire logic [7:0]               CMD_CODE_I,
  input  wire logic                     CMD_ACK_O,
  input  wire logic                     CMD_NAK_O,
  // Run and power stage
  input  wire logic                     RUN_I,
  input  wire logic                     RUN_OE_O,
  input  wire logic [rsq_pkg::MV_W-1:0] DAC_O,
  input  wire logic                     DRIVE_EN_O,
  input  wire logic                     DCM_O,
  input  wire logic                     DECAY_CHECK_EN_I,
  // Status
  input  wire logic                     OT_WARN_MASK_I,
  input  wire logic                     STATUS_CLEAR_I,
  input  wire logic [7:0]               STATUS_BYTE_O,
  input  wire logic [7:0]               STATUS_TEMP_O,
  input  wire logic                     TOFF_WARN_O,
  input  wire logic                     ALERT_O
);
  import rsq_pkg::*;
  logic acc_v;
  logic map_v;
  assign acc_v = CMD_WR_I | CMD_RD_I;
  assign map_v = CMD_CODE_I inside {CMD_SLEW, CMD_ON_DLY, CMD_RISE,
    CMD_ON_MAX, CMD_OFF_DLY, CMD_FALL, CMD_OFF_WARN, CMD_RETRY,
    CMD_RESTART, CMD_OT_WARN, CMD_UT_FAULT};
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  property p_ack;
    acc_v && map_v |=> CMD_ACK_O && !CMD_NAK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_nak;
    acc_v && !map_v |=> CMD_NAK_O && !CMD_ACK_O;
  endproperty
  a_nak: assert property (p_nak) else $error("nak missing");
  property p_stb;
    STATUS_BYTE_O[2] == (STATUS_TEMP_O[6] | STATUS_TEMP_O[4]);
  endproperty
  a_stb: assert property (p_stb) else $error("summary bit wrong");
  property p_alert;
    STATUS_TEMP_O[6] && !OT_WARN_MASK_I && !STATUS_CLEAR_I |=> ALERT_O;
  endproperty
  a_alert: assert property (p_alert) else $error("alert low");
  property p_slope;
    DCM_O && $changed(DAC_O) |=> $stable(DAC_O)[*2];
  endproperty
  a_slope: assert property (p_slope) else $error("ramp too steep");
  property p_drive;
    $fell(DRIVE_EN_O) |-> DAC_O == '0;
  endproperty
  a_drive: assert property (p_drive) else $error("drive off early");
  property p_dcm;
    DCM_O |-> DRIVE_EN_O;
  endproperty
  a_dcm: assert property (p_dcm) else $error("rise without drive");
  property p_runoe;
    $fell(RUN_I) |=> RUN_OE_O;
  endproperty
  a_runoe: assert property (p_runoe) else $error("run not held");
  property p_toff;
    !DECAY_CHECK_EN_I && !TOFF_WARN_O |=> !TOFF_WARN_O;
  endproperty
  a_toff: assert property (p_toff) else $error("decay warn set");
endmodule

bind rsq_sequencer rsq_checker rsq_checker_inst (.SYS_CLK_I, .RST_I,
  .CMD_WR_I, .CMD_RD_I, .CMD_CODE_I, .CMD_ACK_O, .CMD_NAK_O, .RUN_I,
  .RUN_OE_O, .DAC_O, .DRIVE_EN_O, .DCM_O, .DECAY_CHECK_EN_I,
  .OT_WARN_MASK_I, .STATUS_CLEAR_I, .STATUS_BYTE_O, .STATUS_TEMP_O,
  .TOFF_WARN_O, .ALERT_O);

// ===== verif/rsq_rail_model.sv
`timescale 1ns/1ns
module rsq_rail_model #(
  parameter int UV_MV = 900
) (
  input  wire logic                     clk_i,
  input  wire logic [rsq_pkg::MV_W-1:0] dac_i,
  input  wire logic                     drive_i,
  input  wire logic [rsq_pkg::MV_W-1:0] sp_i,
  output logic                          above_uv_o,
  output logic                          below_decay_o
);
  import rsq_pkg::*;
  logic [MV_W-1:0] v_ff;
  initial v_ff = '0;
  // Rail follows DAC, bleeds down when released
  always @(posedge clk_i)
    v_ff <= drive_i ? dac_i : (v_ff > 13'h0004 ? v_ff - 13'h0004 : '0);
  assign above_uv_o    = v_ff >= MV_W'(UV_MV);
  assign below_decay_o = {v_ff, 3'b000} < {3'b000, sp_i};
endmodule

// ===== verif/rsq_sequencer_bench.sv
`timescale 1ns/1ns
module rsq_sequencer_bench;
  import rsq_pkg::*;
  logic             clk, rst, wr, rd, run_drv, op_on, fault, clr, ut_ign;
  logic             val, dec_en, ack, nak, run_oe, drv, dcm, above, below;
  logic             alert, run_pin, ton, toff;
  logic [7:0]       code, sbyte, stemp;
  logic [LIN_W-1:0] wdata, temp, rdata;
  logic [MV_W-1:0]  sp, dac;
  int               n_fail, checks_done, cyc, k, nw;
  logic [7:0]  codes [11] = '{8'h27, 8'h60, 8'h61, 8'h62, 8'h64, 8'h65,
                              8'h66, 8'hDB, 8'hDC, 8'h51, 8'h53};
  logic [15:0] rstv [11] = '{16'hAA00, 16'h8000, 16'hD200, 16'hD280,
    16'h8000, 16'hD200, 16'hF258, 16'hFABC, 16'hFBE8, 16'hEAA8, 16'hE580};
  assign run_pin = run_drv & ~run_oe;
  rsq_sequencer rsq_sequencer_inst (
    .SYS_CLK_I(clk), .RST_I(rst), .CMD_WR_I(wr), .CMD_RD_I(rd),
    .CMD_CODE_I(code), .CMD_DATA_I(wdata), .RD_DATA_O(rdata),
    .CMD_ACK_O(ack), .CMD_NAK_O(nak), .RUN_I(run_pin), .RUN_O(),
    .RUN_OE_O(run_oe), .OP_ON_I(op_on), .SETPOINT_I(sp), .FAULT_I(fault),
    .FAULT_RETRY_I(1'b0), .DECAY_CHECK_EN_I(dec_en),
    .VOUT_ABOVE_UV_I(above), .VOUT_BELOW_DECAY_I(below), .DAC_O(dac),
    .DRIVE_EN_O(drv), .DCM_O(dcm), .TEMP_I(temp), .TEMP_VALID_I(val),
    .OT_WARN_MASK_I(1'b0), .UT_IGNORE_I(ut_ign), .STATUS_CLEAR_I(clr),
    .STATUS_BYTE_O(sbyte), .STATUS_TEMP_O(stemp), .TON_FAULT_O(ton),
    .TOFF_WARN_O(toff), .ALERT_O(alert));
  rsq_rail_model rsq_rail_model_inst (.clk_i(clk), .dac_i(dac),
    .drive_i(drv), .sp_i(sp), .above_uv_o(above), .below_decay_o(below));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_fail++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Command access, then acknowledge and refusal compared
  task automatic acc(input logic w, input logic [7:0] c,
                     input logic [15:0] d, input logic [1:0] an);
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    code <= c;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    chk({14'h0000, ack, nak}, {14'h0000, an});
  endtask
  task automatic tval(input logic [15:0] t);
    @(posedge clk);
    temp <= t;
    val <= 1'b1;
    @(posedge clk);
    val <= 1'b0;
    #1;
  endtask
  task automatic clrst;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    #1;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return drv;
      1: return dcm;
      2: return run_oe;
      default: return dac < sp;
    endcase
  endfunction
  // Bounded wait for a level, cycles counted in nw
  task automatic wt(input int s, input logic lvl, input int lim);
    nw = 0;
    while (sig(s) !== lvl && nw < lim)
    begin
      @(posedge clk);
      #1;
      nw++;
    end
    chk({15'h0000, sig(s)}, {15'h0000, lvl});
  endtask
  initial
  begin
    {wr, rd, run_drv, op_on, fault, clr, ut_ign, val, dec_en} = 9'h000;
    {code, wdata, temp} = 40'h00_0000_0000;
    n_fail = 0;
    checks_done = 0;
    cyc = 0;
    rst = 1'b1;
    sp = 13'h03E8;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 11; k++)
    begin
      acc(1'b0, codes[k], 16'h0000, 2'b10);
      chk(rdata, rstv[k]);
    end
    acc(1'b0, 8'h00, 16'h0000, 2'b01);
    chk(rdata, 16'h0000);
    tval(16'hEB20);
    chk({stemp, sbyte}, 16'h4004);
    chk({15'h0000, alert}, 16'h0001);
    clrst;
    tval(16'hEA80);
    chk({8'h00, stemp}, 16'h0000);
    ut_ign <= 1'b1;
    tval(16'hEE70);
    chk({8'h00, stemp}, 16'h0010);
    acc(1'b0, 8'h60, 16'h0000, 2'b10);
    chk({15'h0000, alert}, 16'h0000);
    tval(16'hEA80);
    clrst;
    // Restart delay kept short for run time
    for (k = 1; k < 9; k++)
      if (codes[k] inside {8'h60, 8'h61, 8'h64, 8'h65, 8'hDC})
        acc(1'b1, codes[k], 16'hF801, 2'b10);
    acc(1'b0, 8'h65, 16'h0000, 2'b10);
    chk(rdata, 16'hF801);
    run_drv <= 1'b1;
    op_on <= 1'b1;
    wt(0, 1'b1, 7000);
    chk({15'h0000, nw >= 4990 && nw <= 5700}, 16'h0001);
    chk({15'h0000, dcm}, 16'h0001);
    wt(1, 1'b0, 8000);
    chk({3'b000, dac}, {3'b000, sp});
    sp <= 13'h03F2;
    repeat (100) @(posedge clk);
    #1;
    chk({15'h0000, dac > 13'h03E8 && dac < 13'h03F2}, 16'h0001);
    repeat (500) @(posedge clk);
    #1;
    chk({3'b000, dac}, 16'h03F2);
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    repeat (1000) @(posedge clk);
    #1;
    chk({15'h0000, dac < 13'h03F2}, 16'h0001);
    wt(0, 1'b0, 8000);
    chk({3'b000, dac}, 16'h0000);
    chk({14'h0000, ton, toff}, 16'h0000);
    run_drv <= 1'b0;
    wt(2, 1'b1, 3);
    run_drv <= 1'b1;
    dec_en <= 1'b1;
    wt(2, 1'b0, 7000);
    chk({15'h0000, nw >= 4990 && nw <= 5700}, 16'h0001);
    wt(0, 1'b1, 7000);
    wt(1, 1'b0, 8000);
    acc(1'b1, 8'h65, 16'h0000, 2'b10);
    op_on <= 1'b0;
    repeat (4000) @(posedge clk);
    #1;
    chk({3'b000, dac}, 16'h03F2);
    wt(3, 1'b1, 2000);
    wt(0, 1'b0, 6000);
    chk({15'h0000, nw >= 2400 && nw <= 3800}, 16'h0001);
    acc(1'b1, 8'h61, 16'h0000, 2'b10);
    op_on <= 1'b1;
    wt(0, 1'b1, 7000);
    chk({3'b000, dac}, {3'b000, sp});
    report_and_stop;
  end
endmodule
